/* File: hdl/pmc_pkg.sv */
/*
 Package for the power mode controller: register offsets, field
 positions, reset values, timing counts, mode encodings, carrier structs.
 Assumes a 125 MHz APB clock and 32-bit data.
*/
// Summary of operation
// - Five modes: normal, idle, stop, suspend, sleep
// - Idle entered after idle-setting write completes
// - Idle keeps state; peripherals keep running
// - Idle ends on enabled interrupt or reset
// - Interrupt clears idle bit, CPU resumes
// - Reset ending idle restarts core at zero
// - Watchdog reset ends idle when enabled
// - Stop entered after stop-setting write completes
// - Stop halts CPU and precision oscillator
// - Stop exits only by reset, restart zero
// - Missing clock reset ends stop when enabled
// - Suspend gates clock, oscillators off, wake resumes
// - Sleep gates supply; comparator wake two-cell only
// - Wake flags read zero two clocks after wake
// - Reset pin fall always wakes suspend or sleep; stay awake
package pmc_pkg;
   localparam logic [7:0] PMC_OFS_PCTL = 8'h00;
   localparam logic [7:0] PMC_OFS_WCFG = 8'h04;
   localparam logic [7:0] PMC_OFS_MODE = 8'h08;
   localparam logic [7:0] PMC_OFS_IST = 8'h0C;
   localparam logic [7:0] PMC_OFS_IMSK = 8'h10;
   localparam int PMC_BIT_IDLE = 0;
   localparam int PMC_BIT_STOP = 1;
   localparam int PMC_BIT_SUSP = 6;
   localparam int PMC_BIT_SLEEP = 7;
   localparam logic [3:0] PMC_WEN_RESET = 4'h0;
   localparam logic [4:0] PMC_IRQ_RESET = 5'h00;
   localparam int PMC_FLAG_HOLD_CYC = 2;
   localparam int PMC_CLK_MHZ = 125;
   localparam int PMC_RSTPIN_NS = 15000;
   localparam int PMC_RSTPIN_CYC = (PMC_RSTPIN_NS * PMC_CLK_MHZ + 999) / 1000 + 1;
   typedef enum logic [4:0] {
      PMC_NORMAL = 5'b0_0001,
      PMC_IDLE = 5'b0_0010,
      PMC_STOP = 5'b0_0100,
      PMC_SUSPEND = 5'b0_1000,
      PMC_SLEEP = 5'b1_0000
   } pmc_mode_type;
   typedef struct packed {
      logic rtc_fail;
      logic rtc_alarm;
      logic port_match;
      logic wake_comparator;
   } pmc_wake_type;
   typedef struct packed {
      logic cpu_halt;
      logic precision_osc_off;
      logic sysclk_gate;
      logic all_osc_off;
      logic supply_gate;
   } pmc_ctl_type;
endpackage

/* File: hdl/pmc_top.sv */
/*
 Power mode controller: APB slave holding power control, wake config,
 mode, interrupt status and mask registers, and the five-state mode FSM.
 Assumes APB master on pclk; wake sources and reset pin are asynchronous
 and are double-registered before use; CPU pulses are synchronous.
*/
`timescale 1ns/1ps
module pmc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_done,
   input wire logic enabled_irq,
   input wire logic int_reset,
   input wire logic two_cell_mode,
   input wire logic rst_pin_n,
   input wire pmc_pkg::pmc_wake_type wake_in,
   output pmc_pkg::pmc_ctl_type ctl_out,
   output logic resume_irq,
   output logic restart_zero,
   output logic wake_req,
   output logic irq
);
   import pmc_pkg::*;

   pmc_mode_type mode_reg, mode_next;
   logic [1:0] pctl_reg;
   logic [1:0] pend_reg;
   logic [1:0] wsusp_reg;
   logic [3:0] wen_reg;
   logic [3:0] wflag_reg;
   logic [4:0] ist_reg;
   logic [4:0] imsk_reg;
   logic [1:0] hold_reg;
   logic [3:0] wk_s1_reg, wk_s2_reg, wk_s3_reg;
   logic rp_s1_reg, rp_s2_reg, rp_s3_reg;
   logic resume_reg, restart_reg, wake_req_reg, irq_reg;
   pmc_ctl_type ctl_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // Address decode for APB
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire sel_pctl = hit(paddr, PMC_OFS_PCTL);
   wire sel_wcfg = hit(paddr, PMC_OFS_WCFG);
   wire sel_mode = hit(paddr, PMC_OFS_MODE);
   wire sel_ist = hit(paddr, PMC_OFS_IST);
   wire sel_imsk = hit(paddr, PMC_OFS_IMSK);
   wire mapped = sel_pctl | sel_wcfg | sel_mode | sel_ist | sel_imsk;

   // Synchronised wake sources and reset pin falling edge
   wire [3:0] wk_rise = wk_s2_reg & ~wk_s3_reg;
   wire rp_fall = ~rp_s2_reg & rp_s3_reg;
   // Comparator wake only valid with a two-cell supply in sleep
   wire cmp_ok = (mode_reg != PMC_SLEEP) || two_cell_mode;
   wire [3:0] wk_en_hit = wk_rise & wen_reg & {3'b111, cmp_ok};
   wire low_wake = (|wk_en_hit) || rp_fall;
   wire in_low = (mode_reg == PMC_SUSPEND) || (mode_reg == PMC_SLEEP);

   // Write to power control stays pending until the instruction ends
   wire pctl_wr = wr && sel_pctl;
   wire [1:0] pctl_req = pctl_wr ? pwdata[PMC_BIT_STOP:PMC_BIT_IDLE] : pend_reg;
   wire [1:0] wcfg_req = (wr && sel_wcfg) ? pwdata[PMC_BIT_SLEEP:PMC_BIT_SUSP] : wsusp_reg;
   wire any_reset = int_reset;

   // Mode transitions
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         PMC_NORMAL: begin
            if (instr_done && pctl_req[1]) begin
               mode_next = PMC_STOP;
            end else if (instr_done && pctl_req[0]) begin
               mode_next = PMC_IDLE;
            end else if (instr_done && wcfg_req[1]) begin
               mode_next = PMC_SLEEP;
            end else if (instr_done && wcfg_req[0]) begin
               mode_next = PMC_SUSPEND;
            end
         end
         PMC_IDLE: begin
            if (any_reset || enabled_irq) begin
               mode_next = PMC_NORMAL;
            end
         end
         PMC_STOP: begin
            if (any_reset) begin
               mode_next = PMC_NORMAL;
            end
         end
         PMC_SUSPEND, PMC_SLEEP: begin
            if (low_wake || any_reset) begin
               mode_next = PMC_NORMAL;
            end
         end
         default: mode_next = PMC_NORMAL;
      endcase
   end

   wire leaving_low = in_low && (mode_next == PMC_NORMAL);
   wire enter_any = (mode_reg == PMC_NORMAL) && (mode_next != PMC_NORMAL);
   // Events: 0 idle exit, 1 stop exit, 2 low wake, 3 pin edge, 4 entry
   wire [4:0] ev = {enter_any, rp_fall, leaving_low,
                    (mode_reg == PMC_STOP) && any_reset,
                    (mode_reg == PMC_IDLE) && (mode_next == PMC_NORMAL)};
   wire [4:0] ist_clr = (wr && sel_ist) ? pwdata[4:0] : 5'h00;

   // Controls derived from next mode so outputs are registered
   pmc_ctl_type ctl_next;
   assign ctl_next.cpu_halt = mode_next != PMC_NORMAL;
   assign ctl_next.precision_osc_off = mode_next == PMC_STOP;
   assign ctl_next.sysclk_gate = (mode_next == PMC_SUSPEND) || (mode_next == PMC_SLEEP);
   assign ctl_next.all_osc_off = (mode_next == PMC_SUSPEND) || (mode_next == PMC_SLEEP);
   assign ctl_next.supply_gate = mode_next == PMC_SLEEP;

   // Read mux; wake flags masked during the settle window
   wire [3:0] flag_vis = (hold_reg != 2'd0) ? 4'h0 : wflag_reg;
   wire [31:0] rd_mux =
      sel_pctl ? {30'h0, pctl_reg} :
      sel_wcfg ? {24'h0, wsusp_reg, 2'b00, flag_vis} :
      sel_mode ? {27'h0, mode_reg} :
      sel_ist ? {27'h0, ist_reg} :
      sel_imsk ? {27'h0, imsk_reg} : 32'h0000_0000;

   // Input synchronisers; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wk_s1_reg <= 4'h0;
         wk_s2_reg <= 4'h0;
         wk_s3_reg <= 4'h0;
         rp_s1_reg <= 1'b1;
         rp_s2_reg <= 1'b1;
         rp_s3_reg <= 1'b1;
      end else begin
         wk_s1_reg <= wake_in;
         wk_s2_reg <= wk_s1_reg;
         wk_s3_reg <= wk_s2_reg;
         rp_s1_reg <= rst_pin_n;
         rp_s2_reg <= rp_s1_reg;
         rp_s3_reg <= rp_s2_reg;
      end
   end

   // Mode state and mode-select bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= PMC_NORMAL;
         pctl_reg <= 2'b00;
         pend_reg <= 2'b00;
         wsusp_reg <= 2'b00;
      end else begin
         mode_reg <= mode_next;
         if (any_reset) begin
            pctl_reg <= 2'b00;
            pend_reg <= 2'b00;
            wsusp_reg <= 2'b00;
         end else if (mode_reg == PMC_IDLE && enabled_irq) begin
            pctl_reg <= 2'b00;
         end else if (leaving_low) begin
            wsusp_reg <= 2'b00;
         end else begin
            if (pctl_wr) begin
               pctl_reg <= pwdata[PMC_BIT_STOP:PMC_BIT_IDLE];
            end
            pend_reg <= (mode_reg == PMC_NORMAL && instr_done) ? 2'b00 : pctl_req;
            wsusp_reg <= (mode_reg == PMC_NORMAL && instr_done) ? 2'b00 : wcfg_req;
         end
      end
   end

   // Wake enables, flags and settle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wen_reg <= PMC_WEN_RESET;
         wflag_reg <= 4'h0;
         hold_reg <= 2'd0;
      end else begin
         if (wr && sel_wcfg) begin
            wen_reg <= pwdata[3:0];
            wflag_reg <= wk_rise;
         end else if (leaving_low) begin
            wen_reg <= 4'h0;
            wflag_reg <= wflag_reg | wk_rise;
         end else begin
            wflag_reg <= wflag_reg | wk_rise;
         end
         hold_reg <= leaving_low ? 2'(PMC_FLAG_HOLD_CYC) :
                     (hold_reg != 2'd0) ? hold_reg - 2'd1 : 2'd0;
      end
   end

   // Interrupt status: set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_reg <= PMC_IRQ_RESET;
         imsk_reg <= PMC_IRQ_RESET;
         irq_reg <= 1'b0;
      end else begin
         ist_reg <= (ist_reg & ~ist_clr) | ev;
         if (wr && sel_imsk) begin
            imsk_reg <= pwdata[4:0];
         end
         irq_reg <= |(((ist_reg & ~ist_clr) | ev) & ((wr && sel_imsk) ? pwdata[4:0] : imsk_reg));
      end
   end

   // Registered outputs and APB answer, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg <= '0;
         resume_reg <= 1'b0;
         restart_reg <= 1'b0;
         wake_req_reg <= 1'b1;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         resume_reg <= (mode_reg != PMC_NORMAL) && (mode_next == PMC_NORMAL) && !any_reset;
         restart_reg <= any_reset && (mode_reg != PMC_NORMAL);
         wake_req_reg <= !((mode_next == PMC_SLEEP));
         prdata_reg <= (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
         pslverr_reg <= psel && !penable && !mapped;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign ctl_out = ctl_reg;
   assign resume_irq = resume_reg;
   assign restart_zero = restart_reg;
   assign wake_req = wake_req_reg;
   assign irq = irq_reg;

   // Checks
   AST_STOP_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_NORMAL && instr_done && pctl_req == 2'b11 && !any_reset)
      |=> mode_reg == PMC_STOP) else $error("stop did not take precedence");
   AST_IDLE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_NORMAL && instr_done && pctl_req == 2'b01)
      |=> mode_reg == PMC_IDLE && ctl_out.cpu_halt) else $error("idle not entered");
   AST_IDLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_IDLE && !enabled_irq && !any_reset) |=> mode_reg == PMC_IDLE)
      else $error("idle left without cause");
   AST_IDLE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_IDLE && enabled_irq && !any_reset)
      |=> pctl_reg == 2'b00 && resume_irq) else $error("idle bit not cleared");
   AST_STOP_ONLY_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_STOP && !any_reset) |=> mode_reg == PMC_STOP)
      else $error("stop left without reset");
   AST_STOP_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_STOP && any_reset) |=> restart_zero && mode_reg == PMC_NORMAL)
      else $error("stop reset not restarting");
   AST_FLAG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      leaving_low |=> (flag_vis == 4'h0) [*2]) else $error("flags visible too early");
   AST_PIN_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
      (in_low && rp_fall) |=> mode_reg == PMC_NORMAL && !ctl_out.sysclk_gate)
      else $error("pin edge did not wake");
   AST_STOP_OSC: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg == PMC_STOP) |-> ctl_out.precision_osc_off && ctl_out.cpu_halt)
      else $error("oscillator running in stop");
   COV_IDLE: cover property (@(posedge pclk) mode_reg == PMC_IDLE ##[1:20] mode_reg == PMC_NORMAL);
   COV_STOP: cover property (@(posedge pclk) mode_reg == PMC_STOP ##[1:20] restart_zero);
   COV_SLEEP: cover property (@(posedge pclk) mode_reg == PMC_SLEEP ##[1:50] resume_irq);
endmodule

/* File: verif/pmc_cpu_model.sv */
/*
 CPU core model for the power mode controller bench.
 Assumes the pclk domain; retires instructions only while not halted.
*/
`timescale 1ns/1ps
module pmc_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cpu_halt,
   output logic instr_done
);
   logic [1:0] phase_reg;
   // Flash one-shot taken as kept active by software before idle/stop
   // Four-clock instructions, so entry lags the write; a halted core retires nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= 2'h0;
         instr_done <= 1'b0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         instr_done <= (phase_reg == 2'h3) && !cpu_halt;
      end
   end
endmodule

/* File: verif/power_mode_controller_test.sv */
/*
 Self-checking bench for the power mode controller: APB tasks, mode scenarios.
 Assumes pmc_top and the CPU model; the bench plays interrupts and wake sources.
*/
`timescale 1ns/1ps
module power_mode_controller_test;
   import pmc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic instr_done, enabled_irq, int_reset, two_cell_mode, rst_pin_n;
   logic resume_irq, restart_zero, wake_req, irq, irq_a;
   pmc_wake_type wake_in;
   pmc_ctl_type ctl_out;
   int n_mismatch = 0;
   int check_count = 0;
   int n_res = 0;
   int n_rst = 0;
   int old;

   pmc_top i_pmc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .instr_done, .enabled_irq, .int_reset,
      .two_cell_mode, .rst_pin_n, .wake_in, .ctl_out, .resume_irq, .restart_zero,
      .wake_req, .irq);
   pmc_cpu_model i_pmc_cpu_model (.pclk, .presetn, .cpu_halt(ctl_out.cpu_halt),
      .instr_done);

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Count one-cycle resume and restart pulses
   always @(posedge pclk) begin
      if (resume_irq === 1'b1) n_res++;
      if (restart_zero === 1'b1) n_rst++;
   end

   task results;
      if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error taken at the pready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_mismatch++;
         results;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Poll the mode register, bounded
   task wait_mode(input pmc_mode_type m);
      int n;
      n = 0;
      do begin
         apb(1'b0, PMC_OFS_MODE, 32'h0000_0000);
         n++;
      end while (rd !== 32'(m) && n < 40);
      chk(rd, 32'(m));
      if (rd !== 32'(m)) begin
         results;
      end
   endtask

   // 0: enabled interrupt, 1: reset request, 2: reset pin low long enough to sync
   task pulse(input int k);
      @(posedge pclk);
      enabled_irq <= (k == 0);
      int_reset <= (k == 1);
      rst_pin_n <= (k != 2);
      repeat (k == 2 ? 4 : 1) @(posedge pclk);
      enabled_irq <= 1'b0;
      int_reset <= 1'b0;
      rst_pin_n <= 1'b1;
   endtask

   initial begin
      {presetn, psel, penable, pwrite, enabled_irq, int_reset, two_cell_mode} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rst_pin_n = 1'b1;
      wake_in = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_mode(PMC_NORMAL);
      chk(32'(wake_req), 32'h0000_0001);
      apb(1'b0, 8'h3C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      // Idle: foreign wake events ignored, interrupt resumes
      apb(1'b1, PMC_OFS_PCTL, 32'h0000_0001);
      wait_mode(PMC_IDLE);
      chk(32'(ctl_out), 32'h0000_0010);
      @(posedge pclk) wake_in <= 4'hF;
      repeat (6) @(posedge pclk);
      wake_in <= 4'h0;
      wait_mode(PMC_IDLE);
      old = n_res;
      pulse(0);
      wait_mode(PMC_NORMAL);
      chk(n_res - old, 1);
      apb(1'b0, PMC_OFS_PCTL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // Status, mask direction, write-one-to-clear
      apb(1'b0, PMC_OFS_IST, 32'h0000_0000);
      chk(32'(rd[0]), 32'h0000_0001);
      irq_a = irq;
      apb(1'b1, PMC_OFS_IMSK, 32'h0000_001F);
      apb(1'b0, PMC_OFS_IMSK, 32'h0000_0000);
      chk(rd, 32'h0000_001F);
      chk(32'(irq ^ irq_a), 32'h0000_0001);
      apb(1'b1, PMC_OFS_IST, 32'h0000_001F);
      apb(1'b0, PMC_OFS_IST, 32'h0000_0000);
      chk({rd[31:1], irq}, 32'h0000_0000);
      // Idle ended by a watchdog-style reset
      apb(1'b1, PMC_OFS_PCTL, 32'h0000_0001);
      wait_mode(PMC_IDLE);
      old = n_rst;
      pulse(1);
      wait_mode(PMC_NORMAL);
      chk(n_rst - old, 1);
      // Both bits set: stop wins, interrupts cannot end it
      apb(1'b1, PMC_OFS_PCTL, 32'h0000_0003);
      wait_mode(PMC_STOP);
      chk(32'(ctl_out), 32'h0000_0018);
      pulse(0);
      repeat (4) @(posedge pclk);
      wait_mode(PMC_STOP);
      old = n_rst;
      pulse(1);
      wait_mode(PMC_NORMAL);
      chk(n_rst - old, 1);
      // Suspend with port match wake enabled in the entering write
      apb(1'b1, PMC_OFS_WCFG, 32'h0000_0042);
      wait_mode(PMC_SUSPEND);
      chk({ctl_out.sysclk_gate, ctl_out.all_osc_off, wake_req}, 3'b111);
      old = n_res;
      @(posedge pclk) wake_in <= 4'h2;
      wait_mode(PMC_NORMAL);
      wake_in <= 4'h0;
      chk(n_res - old, 1);
      apb(1'b0, PMC_OFS_WCFG, 32'h0000_0000);
      chk(32'(rd[1]), 32'h0000_0001);
      // Sleep in one-cell mode: comparator ignored, reset pin wakes
      apb(1'b1, PMC_OFS_WCFG, 32'h0000_0081);
      wait_mode(PMC_SLEEP);
      chk({ctl_out.supply_gate, wake_req}, 2'b10);
      @(posedge pclk) wake_in <= 4'h1;
      repeat (6) @(posedge pclk);
      wake_in <= 4'h0;
      wait_mode(PMC_SLEEP);
      pulse(2);
      wait_mode(PMC_NORMAL);
      apb(1'b0, PMC_OFS_IST, 32'h0000_0000);
      chk(32'(rd[3]), 32'h0000_0001);
      repeat (PMC_RSTPIN_CYC) @(posedge pclk);
      // Two-cell mode: comparator wakes from sleep
      two_cell_mode <= 1'b1;
      apb(1'b1, PMC_OFS_WCFG, 32'h0000_0081);
      wait_mode(PMC_SLEEP);
      @(posedge pclk) wake_in <= 4'h1;
      wait_mode(PMC_NORMAL);
      results;
   end
endmodule
